/* File: common/mmu_guard_pkg.sv */
// constants and types shared by the memory and register access guard
package mmu_guard_pkg;

   localparam int SEG_COUNT = 64;
   localparam int SEG_IDX_W = 6;
   localparam int ADDR_W = 16;
   localparam int HW_COMP_W = 16;

   // bus register byte offsets
   localparam logic [7:0] OFS_SEG_SEL = 8'h00;
   localparam logic [7:0] OFS_SEG_FIRST = 8'h04;
   localparam logic [7:0] OFS_SEG_LAST = 8'h08;
   localparam logic [7:0] OFS_SEG_RELOC = 8'h0c;
   localparam logic [7:0] OFS_SEG_RIGHTS = 8'h10;
   localparam logic [7:0] OFS_TABLE_PTR = 8'h14;
   localparam logic [7:0] OFS_FW_CTRL_LO = 8'h18;
   localparam logic [7:0] OFS_FW_CTRL_HI = 8'h1c;
   localparam logic [7:0] OFS_EXCH_BASE_LO = 8'h20;
   localparam logic [7:0] OFS_EXCH_BASE_HI = 8'h24;
   localparam logic [7:0] OFS_EXCH_SIZE_LO = 8'h28;
   localparam logic [7:0] OFS_EXCH_SIZE_HI = 8'h2c;
   localparam logic [7:0] OFS_STATUS = 8'h30;

   // reset values
   localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] RST_RIGHTS = 5'h00;

   // segment rights field positions
   localparam int RIGHT_R = 0;
   localparam int RIGHT_W = 1;
   localparam int RIGHT_X = 2;
   localparam int RIGHT_HW_R = 3;
   localparam int RIGHT_HW_W = 4;
   localparam int RIGHTS_W = 5;

   // status field positions
   localparam int ST_MODE_LSB = 0;
   localparam int ST_MEM_FAULT = 3;
   localparam int ST_SFR_DENY = 4;
   localparam int ST_SEG_LSB = 5;

   // mode derivation
   localparam int PSW_SYSTEM_BIT = 3;
   localparam logic [1:0] INT_BITS_BOOT = 2'h1;
   localparam logic [1:0] INT_BITS_TEST = 2'h2;
   localparam logic [1:0] INT_BITS_CLOS = 2'h3;

   // fixed physical partitions
   localparam logic [ADDR_W-1:0] ROM_TEST_LAST = 16'h0fff;
   localparam logic [ADDR_W-1:0] ROM_LAST = 16'h7fff;
   localparam logic [ADDR_W-1:0] EE_FIRST = 16'h8000;
   localparam logic [ADDR_W-1:0] EE_CLOS_LAST = 16'h83ff;
   localparam logic [ADDR_W-1:0] EE_LAST = 16'hbfff;
   localparam logic [ADDR_W-1:0] RAM_FIRST = 16'hc000;
   localparam logic [ADDR_W-1:0] RAM_CLOS_SIZE = 16'h0000;

   typedef enum logic [2:0] {MODE_BOOT, MODE_TEST, MODE_CLOS, MODE_SYSTEM, MODE_USER} cpu_mode_t;
   typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_EXEC, ACC_NONE} acc_kind_t;
   typedef enum logic [2:0] {GRP_CPU, GRP_SEG_CFG, GRP_SYS_MGMT, GRP_FW_CFG, GRP_CLOS, GRP_TEST, GRP_HW} sfr_group_t;

endpackage

/* File: dv/cpu_model.sv */
// cpu core model issuing mode, memory and special register requests
`timescale 1ns/1ps
module cpu_model
   import mmu_guard_pkg::*;
(
   input wire logic hclk,
   output logic [7:0] program_status_high_word,
   output logic [1:0] internal_mode_bits,
   output logic cpu_valid,
   output acc_kind_t cpu_kind,
   output logic [ADDR_W-1:0] cpu_vaddr,
   output logic [7:0] cpu_wdata,
   output logic sfr_valid,
   output logic sfr_write,
   output sfr_group_t sfr_group,
   output logic [3:0] sfr_hw_idx,
   output logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata_in
);
   initial begin
      program_status_high_word = 8'h00;
      internal_mode_bits = 2'h0;
      cpu_valid = 1'b0;
      sfr_valid = 1'b0;
   end
   ////////////////////////////////////////
   task automatic set_mode(input int m);
      @(posedge hclk);
      internal_mode_bits <= m < 3 ? 2'(m + 1) : 2'h0;
      program_status_high_word <= m == 3 ? 8'h08 : 8'h00;
   endtask
   task automatic mem(input int k, input logic [15:0] a, input logic [7:0] d);
      @(posedge hclk);
      cpu_valid <= 1'b1;
      cpu_kind <= acc_kind_t'(k);
      cpu_vaddr <= a;
      cpu_wdata <= d;
      @(posedge hclk);
      cpu_valid <= 1'b0;
      cpu_vaddr <= ~a;
   endtask
   task automatic sfr(input int g, input bit wr, input logic [3:0] i, input logic [7:0] d, input logic [7:0] r);
      @(posedge hclk);
      sfr_valid <= 1'b1;
      sfr_write <= wr;
      sfr_group <= sfr_group_t'(g);
      sfr_hw_idx <= i;
      sfr_wdata <= d;
      sfr_rdata_in <= r;
      @(posedge hclk);
      sfr_valid <= 1'b0;
      sfr_rdata_in <= ~r;
   endtask
endmodule

/* File: dv/mmu_guard_chk.sv */
// assertions on the guard's bus, memory and special register ports
`timescale 1ns/1ps
module mmu_guard_chk
   import mmu_guard_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [1:0] internal_mode_bits,
   input wire logic cpu_valid,
   input wire acc_kind_t cpu_kind,
   input wire logic [ADDR_W-1:0] cpu_vaddr,
   input wire logic mem_valid,
   input wire acc_kind_t mem_kind,
   input wire logic [ADDR_W-1:0] mem_paddr,
   input wire logic mem_fault,
   input wire logic sfr_valid,
   input wire logic sfr_write,
   input wire sfr_group_t sfr_group,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_ack,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wr_data,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_deny
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////
   a_mem_answer: assert property (cpu_valid |=> mem_valid != mem_fault) else $error("mem answer");
   a_mem_quiet: assert property (!cpu_valid |=> !mem_valid && !mem_fault && mem_kind == ACC_NONE)
      else $error("mem quiet");
   a_none_kind: assert property (cpu_valid && cpu_kind == ACC_NONE |=> mem_fault) else $error("none kind");
   a_test_ident: assert property (cpu_valid && internal_mode_bits == INT_BITS_TEST && cpu_kind == ACC_READ
      |=> mem_valid && mem_paddr == $past(cpu_vaddr)) else $error("test paddr");
   a_sfr_answer: assert property (sfr_valid |=> sfr_ack) else $error("sfr ack");
   a_cpu_group: assert property (sfr_valid && sfr_group == GRP_CPU |=> !sfr_deny) else $error("cpu group");
   a_segcfg_mode: assert property (sfr_valid && sfr_group == GRP_SEG_CFG && internal_mode_bits != 2'h0
      |=> sfr_deny) else $error("segcfg mode");
   a_deny_zero: assert property (sfr_deny |-> sfr_rdata == 8'h00 && !sfr_wr) else $error("deny data");
   a_write_pass: assert property (sfr_valid && sfr_write |=> sfr_wr == !sfr_deny
      && (!sfr_wr || sfr_wr_data == $past(sfr_wdata))) else $error("sfr write");
   a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait");
   a_okay_resp: assert property (!hresp) else $error("hresp");
   c_fault: cover property (mem_fault);
   c_exec: cover property (mem_valid && mem_kind == ACC_EXEC);
   c_wr_deny: cover property (sfr_deny && $past(sfr_write));
endmodule

/* File: dv/tb.sv */
// self-checking bench for the memory and special register access guard
`timescale 1ns/1ps
module tb;
   import mmu_guard_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, internal_mode_bits;
   logic [2:0] hsize;
   logic [7:0] program_status_high_word, cpu_wdata, mem_wdata, sfr_wdata, sfr_rdata_in, sfr_wr_data, sfr_rdata;
   logic cpu_valid, mem_valid, mem_fault, sfr_valid, sfr_write, sfr_ack, sfr_wr, sfr_deny;
   acc_kind_t cpu_kind, mem_kind;
   logic [ADDR_W-1:0] cpu_vaddr, mem_paddr;
   sfr_group_t sfr_group;
   logic [3:0] sfr_hw_idx;
   int errors, checks_done, exec_seg, nseg, pa, hit;
   int fw = 16'h8124;
   int s_first[3] = '{16'h0100, 16'h0200, 16'h0200};
   int s_last[3] = '{16'h01ff, 16'h02ff, 16'h03ff};
   int s_reloc[3] = '{16'h1000, 16'h8400, 16'h8400};
   int s_rights[3] = '{5'h0d, 5'h00, 5'h1e};
   logic [7:0] ro[6] = '{OFS_SEG_LAST, OFS_SEG_RELOC, OFS_SEG_RIGHTS, OFS_TABLE_PTR, OFS_FW_CTRL_HI, 8'h3c};
   int rv[6] = '{16'h03ff, 16'h8400, 5'h1e, 16'hc100, 8'h81, 0};
   assign hready = hreadyout;
   mode_based_mmu_sfr_guard mode_based_mmu_sfr_guard_i (.*);
   cpu_model cpu_model_i (.*);
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   ////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wait_rdy();
      for (int n = 0; n < 100; n++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) return;
      end
      errors++;
      print_verdict();
   endtask
   task automatic bus(input bit wr, input logic [7:0] ofs, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, ofs};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   function automatic bit mem_ok(int m, int k, int a);
      bit w, x, rt, rom, ee, ec;
      w = k == 1;
      x = k == 2;
      rt = a < 16'h1000;
      rom = a < 16'h8000;
      ee = !rom && a < 16'hc000;
      ec = ee && a < 16'h8400;
      pa = a;
      if (k == 3) return 0;
      case (m)
         0, 2: return (rt && !w) || ec;
         1: return (rom && !w) || ee || (!rom && !ee && !x);
         3: return (rom && !rt && !w) || (ee && !ec) || (!rom && !ee && !x);
         default: begin
            for (int i = 0; i < nseg; i++) begin
               if (s_rights[i][2:0] != 0 && a >= s_first[i] && a <= s_last[i]) begin
                  pa = (a + s_reloc[i]) & 16'hffff;
                  hit = i;
                  return s_rights[i][k] && mem_ok(3, k, pa);
               end
            end
            return 0;
         end
      endcase
   endfunction
   function automatic bit sfr_ok(int m, int g, bit wr, int i);
      case (g)
         0: return 1;
         1: return m == 3;
         2: return m != 2 && m != 4;
         3: return m != 4 && !(m == 2 && wr);
         4: return m <= 2;
         5: return m <= 1;
         6: return m == 2 ? fw[i] : m == 4 ? s_rights[exec_seg][wr ? 4 : 3] : 1;
         default: return 0;
      endcase
   endfunction
   task automatic mem_check(input int m, input int k, input int a, input logic [7:0] d);
      bit ok;
      ok = mem_ok(m, k, a);
      cpu_model_i.mem(k, a[15:0], d);
      #1;
      check("mem_valid", mem_valid, ok);
      check("mem_fault", mem_fault, !ok);
      check("mem_paddr", mem_paddr, ok ? pa : 0);
      check("mem_kind", mem_kind, ok ? k : 3);
      check("mem_wdata", mem_wdata, ok ? d : 0);
      if (ok && m == 4 && k == 2) exec_seg = hit;
   endtask
   task automatic sfr_check(input int m, input int g, input bit wr, input logic [3:0] i);
      logic [7:0] d, r;
      bit ok;
      d = 8'($urandom());
      r = 8'($urandom());
      ok = sfr_ok(m, g, wr, i);
      cpu_model_i.sfr(g, wr, i, d, r);
      #1;
      check("sfr_ack", sfr_ack, 1);
      check("sfr_deny", sfr_deny, !ok);
      check("sfr_wr", sfr_wr, ok && wr);
      check("sfr_rdata", sfr_rdata, ok && !wr ? r : 0);
      if (ok && wr) check("sfr_wr_data", sfr_wr_data, d);
   endtask
   ////////////////////////////////////////
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hsize = 3'h2;
      void'($urandom(26));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      check("reset kind", mem_kind, ACC_NONE);
      check("reset ready", hreadyout, 1);
      mem_check(4, 0, 16'h0150, 8'h5a);
      for (int m = 0; m < 5; m++) begin
         cpu_model_i.set_mode(m);
         bus(0, OFS_STATUS, 0);
         check("status mode", rd[2:0], m);
      end
      cpu_model_i.set_mode(3);
      for (int i = 0; i < 3; i++) begin
         bus(1, OFS_SEG_SEL, i);
         bus(1, OFS_SEG_FIRST, s_first[i]);
         bus(1, OFS_SEG_LAST, s_last[i]);
         bus(1, OFS_SEG_RELOC, s_reloc[i]);
         bus(1, OFS_SEG_RIGHTS, s_rights[i]);
      end
      nseg = 3;
      bus(1, OFS_TABLE_PTR, 32'h0000_c100);
      bus(1, OFS_FW_CTRL_LO, fw & 8'hff);
      bus(1, OFS_FW_CTRL_HI, fw >> 8);
      cpu_model_i.set_mode(4);
      bus(1, OFS_SEG_RIGHTS, 32'h0);
      for (int j = 0; j < 3; j++) begin
         cpu_model_i.set_mode(j == 0 ? 3 : j == 1 ? 4 : 2);
         for (int k = 0; k < 6; k++) begin
            bus(0, ro[k], 0);
            check("reg read", rd, (j == 0 || (j == 2 && k == 4)) ? rv[k] : 0);
         end
      end
      for (int n = 0; n < 250; n++) begin
         if (n % 50 == 0) cpu_model_i.set_mode(n / 50);
         mem_check(n / 50, $urandom_range(0, 3), $urandom_range(0, n >= 200 ? 16'h03ff : 16'hffff), 8'($urandom()));
      end
      for (int m = 0; m < 5; m++) begin
         cpu_model_i.set_mode(m);
         for (int g = 0; g < 16; g++) sfr_check(m, g % 8, g / 8, 4'($urandom()));
      end
      print_verdict();
   end
endmodule
bind mode_based_mmu_sfr_guard mmu_guard_chk mmu_guard_chk_i (.*);

/* File: hw/mode_based_mmu_sfr_guard.sv */
// mode based memory translation, memory and register access guard
//
// Behaviour
// RULE1 - five cpu modes come from status high word plus two internal bits
// RULE2 - up to 64 segments hold rights, first, last address and relocation
// RULE3 - each segment also holds hardware register rights for its code
// RULE4 - segment with no read, write or execute right never matches
// RULE5 - any number of segments from none to 64 works
// RULE6 - every cpu address is virtual and translated before memory
// RULE7 - check completes before memory is reached; failing access is blocked
// RULE8 - all reads, writes and executes in every mode are checked
// RULE9 - decision uses mode, segment table, config and system registers
// RULE10 - every special register access is checked in hardware by mode
// RULE11 - user hardware rights from segment, contactless rights from firewall
// RULE12 - denied special register read returns zero
// RULE13 - denied special register write is dropped
// RULE14 - firewall registers set contactless hardware rights and exchange window
// RULE15 - config group holds the segment table pointer
// RULE16 - memories split into fixed partitions per owner
// RULE17 - contactless ram partition has size zero
// RULE18 - applications reach hardware registers only when granted
// RULE19 - segmentation config registers only accessible in system mode
// RULE20 - user memory rights come only from the matching segment
// RULE21 - match between first and last address, add relocation offset
// RULE22 - unmatched or unpermitted access is blocked with no memory effect
`timescale 1ns/1ps

module mode_based_mmu_sfr_guard
   import mmu_guard_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // cpu state
   input wire logic [7:0] program_status_high_word,
   input wire logic [1:0] internal_mode_bits,
   // cpu memory access
   input wire logic cpu_valid,
   input wire acc_kind_t cpu_kind,
   input wire logic [ADDR_W-1:0] cpu_vaddr,
   input wire logic [7:0] cpu_wdata,
   output logic mem_valid,
   output acc_kind_t mem_kind,
   output logic [ADDR_W-1:0] mem_paddr,
   output logic [7:0] mem_wdata,
   output logic mem_fault,
   // cpu special register access
   input wire logic sfr_valid,
   input wire logic sfr_write,
   input wire sfr_group_t sfr_group,
   input wire logic [3:0] sfr_hw_idx,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata_in,
   output logic sfr_ack,
   output logic sfr_wr,
   output logic [7:0] sfr_wr_data,
   output logic [7:0] sfr_rdata,
   output logic sfr_deny
);

   ////////////////////////////////////////////////////////////////////////
   // state

   logic [ADDR_W-1:0] seg_first_q [SEG_COUNT];
   logic [ADDR_W-1:0] seg_last_q [SEG_COUNT];
   logic [ADDR_W-1:0] seg_reloc_q [SEG_COUNT];
   logic [RIGHTS_W-1:0] seg_rights_q [SEG_COUNT];
   logic [SEG_IDX_W-1:0] seg_sel_q;
   logic [ADDR_W-1:0] table_ptr_q;
   logic [7:0] fw_ctrl_lo_q;
   logic [7:0] fw_ctrl_hi_q;
   logic [7:0] exch_base_lo_q;
   logic [7:0] exch_base_hi_q;
   logic [7:0] exch_size_lo_q;
   logic [7:0] exch_size_hi_q;
   logic [SEG_IDX_W-1:0] exec_seg_q;

   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic hresp_q;
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] bus_addr_q;

   logic mem_valid_q;
   acc_kind_t mem_kind_q;
   logic [ADDR_W-1:0] mem_paddr_q;
   logic [7:0] mem_wdata_q;
   logic mem_fault_q;
   logic sfr_ack_q;
   logic sfr_wr_q;
   logic [7:0] sfr_wr_data_q;
   logic [7:0] sfr_rdata_q;
   logic sfr_deny_q;

   ////////////////////////////////////////////////////////////////////////
   // cpu mode

   cpu_mode_t mode;

   always_comb begin
      case (internal_mode_bits) // [RULE1]
         INT_BITS_BOOT: mode = MODE_BOOT;
         INT_BITS_TEST: mode = MODE_TEST;
         INT_BITS_CLOS: mode = MODE_CLOS;
         default: mode = program_status_high_word[PSW_SYSTEM_BIT] ? MODE_SYSTEM : MODE_USER;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // segment match and translation

   logic seg_hit;
   logic [SEG_IDX_W-1:0] seg_idx;
   logic [ADDR_W-1:0] paddr;

   always_comb begin
      seg_hit = 1'b0;
      seg_idx = '0;
      // lowest numbered enabled segment wins
      for (int i = SEG_COUNT - 1; i >= 0; i--) begin
         if (seg_rights_q[i][RIGHT_X:RIGHT_R] != 3'h0 && // [RULE4] [RULE5]
             cpu_vaddr >= seg_first_q[i] && cpu_vaddr <= seg_last_q[i]) begin // [RULE21]
            seg_hit = 1'b1;
            seg_idx = SEG_IDX_W'(i);
         end
      end
   end

   // identity map outside user mode, relocation inside it
   always_comb begin
      if (mode == MODE_USER) begin
         paddr = ADDR_W'(cpu_vaddr + seg_reloc_q[seg_idx]); // [RULE6] [RULE21]
      end else begin
         paddr = cpu_vaddr; // [RULE6]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // physical partitions and memory permission

   logic in_rom, in_rom_test, in_rom_app;
   logic in_ee, in_ee_clos, in_ee_app;
   logic in_ram, in_ram_clos, in_ram_app, in_exch;
   logic kind_rx, kind_rw, seg_right, mem_ok;
   logic [ADDR_W:0] exch_base, exch_end;

   always_comb begin
      in_rom = paddr <= ROM_LAST; // [RULE16]
      in_rom_test = paddr <= ROM_TEST_LAST;
      in_rom_app = in_rom && !in_rom_test;
      in_ee = paddr >= EE_FIRST && paddr <= EE_LAST;
      in_ee_clos = paddr >= EE_FIRST && paddr <= EE_CLOS_LAST;
      in_ee_app = in_ee && !in_ee_clos;
      in_ram = paddr >= RAM_FIRST;
      in_ram_clos = in_ram && ADDR_W'(paddr - RAM_FIRST) < RAM_CLOS_SIZE; // [RULE17]
      in_ram_app = in_ram && !in_ram_clos;
      exch_base = {1'b0, exch_base_hi_q, exch_base_lo_q};
      exch_end = (ADDR_W+1)'(exch_base + {1'b0, exch_size_hi_q, exch_size_lo_q});
      in_exch = in_ram_app && {1'b0, paddr} >= exch_base && {1'b0, paddr} < exch_end; // [RULE14]
      kind_rx = cpu_kind == ACC_READ || cpu_kind == ACC_EXEC;
      kind_rw = cpu_kind == ACC_READ || cpu_kind == ACC_WRITE;
      case (cpu_kind)
         ACC_READ: seg_right = seg_rights_q[seg_idx][RIGHT_R];
         ACC_WRITE: seg_right = seg_rights_q[seg_idx][RIGHT_W];
         ACC_EXEC: seg_right = seg_rights_q[seg_idx][RIGHT_X];
         default: seg_right = 1'b0;
      endcase
      case (mode) // [RULE8] [RULE9]
         MODE_BOOT: mem_ok = (in_rom_test && kind_rx) || in_ee_clos || (in_ram_clos && kind_rw);
         MODE_TEST: mem_ok = (in_rom && kind_rx) || in_ee || (in_ram && kind_rw);
         MODE_CLOS: mem_ok = (in_rom_test && kind_rx) || in_ee_clos || ((in_ram_clos || in_exch) && kind_rw);
         MODE_SYSTEM: mem_ok = (in_rom_app && kind_rx) || in_ee_app || (in_ram_app && kind_rw);
         MODE_USER: mem_ok = seg_hit && seg_right && // [RULE20] [RULE22]
                             ((in_rom_app && kind_rx) || in_ee_app || (in_ram_app && kind_rw));
         default: mem_ok = 1'b0;
      endcase
      if (cpu_kind == ACC_NONE) begin
         mem_ok = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // memory request stage: only checked accesses leave the block

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_valid_q <= 1'b0;
         mem_kind_q <= ACC_NONE;
         mem_paddr_q <= RST_ADDR;
         mem_wdata_q <= RST_BYTE;
         mem_fault_q <= 1'b0;
      end else begin
         mem_valid_q <= cpu_valid && mem_ok; // [RULE7] [RULE22]
         mem_kind_q <= (cpu_valid && mem_ok) ? cpu_kind : ACC_NONE;
         mem_paddr_q <= (cpu_valid && mem_ok) ? paddr : RST_ADDR;
         mem_wdata_q <= (cpu_valid && mem_ok) ? cpu_wdata : RST_BYTE;
         mem_fault_q <= cpu_valid && !mem_ok;
      end
   end

   // segment of the last permitted user fetch, for hardware rights
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exec_seg_q <= '0;
      end else if (cpu_valid && mem_ok && mode == MODE_USER && cpu_kind == ACC_EXEC) begin
         exec_seg_q <= seg_idx; // [RULE11]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // special register gate

   logic hw_ok, sfr_ok;
   logic [HW_COMP_W-1:0] fw_ctrl;

   always_comb begin
      fw_ctrl = {fw_ctrl_hi_q, fw_ctrl_lo_q};
      case (mode)
         MODE_USER: hw_ok = sfr_write ? seg_rights_q[exec_seg_q][RIGHT_HW_W] // [RULE3] [RULE11] [RULE18]
                                      : seg_rights_q[exec_seg_q][RIGHT_HW_R];
         MODE_CLOS: hw_ok = fw_ctrl[sfr_hw_idx]; // [RULE11] [RULE14]
         default: hw_ok = 1'b1;
      endcase
      case (sfr_group) // [RULE10]
         GRP_CPU: sfr_ok = 1'b1;
         GRP_SEG_CFG: sfr_ok = mode == MODE_SYSTEM; // [RULE19]
         GRP_SYS_MGMT: sfr_ok = mode == MODE_BOOT || mode == MODE_TEST || mode == MODE_SYSTEM;
         GRP_FW_CFG: sfr_ok = mode == MODE_BOOT || mode == MODE_TEST || mode == MODE_SYSTEM ||
                              (mode == MODE_CLOS && !sfr_write);
         GRP_CLOS: sfr_ok = mode == MODE_BOOT || mode == MODE_TEST || mode == MODE_CLOS;
         GRP_TEST: sfr_ok = mode == MODE_BOOT || mode == MODE_TEST;
         GRP_HW: sfr_ok = hw_ok; // [RULE18]
         default: sfr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sfr_ack_q <= 1'b0;
         sfr_wr_q <= 1'b0;
         sfr_wr_data_q <= RST_BYTE;
         sfr_rdata_q <= RST_BYTE;
         sfr_deny_q <= 1'b0;
      end else begin
         sfr_ack_q <= sfr_valid;
         sfr_wr_q <= sfr_valid && sfr_write && sfr_ok; // [RULE13]
         sfr_wr_data_q <= (sfr_valid && sfr_write && sfr_ok) ? sfr_wdata : RST_BYTE;
         sfr_rdata_q <= (sfr_valid && !sfr_write && sfr_ok) ? sfr_rdata_in : RST_BYTE; // [RULE12]
         sfr_deny_q <= sfr_valid && !sfr_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register bus: writes in the data phase, reads take one wait state

   logic bus_go;
   logic seg_cfg_ok, fw_wr_ok, fw_rd_ok;
   logic [31:0] rd_val;

   assign bus_go = hsel && htrans[1] && hready;
   assign seg_cfg_ok = mode == MODE_SYSTEM; // [RULE19]
   assign fw_wr_ok = mode == MODE_BOOT || mode == MODE_TEST || mode == MODE_SYSTEM;
   assign fw_rd_ok = fw_wr_ok || mode == MODE_CLOS;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         bus_addr_q <= 8'h00;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         wr_pend_q <= bus_go && hwrite;
         rd_pend_q <= bus_go && !hwrite;
         hreadyout_q <= !(bus_go && !hwrite);
         hresp_q <= 1'b0;
         if (bus_go) begin
            bus_addr_q <= haddr[7:0];
         end
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      case (bus_addr_q)
         OFS_SEG_SEL: rd_val = seg_cfg_ok ? 32'(seg_sel_q) : 32'h0000_0000;
         OFS_SEG_FIRST: rd_val = seg_cfg_ok ? 32'(seg_first_q[seg_sel_q]) : 32'h0000_0000;
         OFS_SEG_LAST: rd_val = seg_cfg_ok ? 32'(seg_last_q[seg_sel_q]) : 32'h0000_0000;
         OFS_SEG_RELOC: rd_val = seg_cfg_ok ? 32'(seg_reloc_q[seg_sel_q]) : 32'h0000_0000;
         OFS_SEG_RIGHTS: rd_val = seg_cfg_ok ? 32'(seg_rights_q[seg_sel_q]) : 32'h0000_0000;
         OFS_TABLE_PTR: rd_val = seg_cfg_ok ? 32'(table_ptr_q) : 32'h0000_0000; // [RULE15]
         OFS_FW_CTRL_LO: rd_val = fw_rd_ok ? 32'(fw_ctrl_lo_q) : 32'h0000_0000;
         OFS_FW_CTRL_HI: rd_val = fw_rd_ok ? 32'(fw_ctrl_hi_q) : 32'h0000_0000;
         OFS_EXCH_BASE_LO: rd_val = fw_rd_ok ? 32'(exch_base_lo_q) : 32'h0000_0000;
         OFS_EXCH_BASE_HI: rd_val = fw_rd_ok ? 32'(exch_base_hi_q) : 32'h0000_0000;
         OFS_EXCH_SIZE_LO: rd_val = fw_rd_ok ? 32'(exch_size_lo_q) : 32'h0000_0000;
         OFS_EXCH_SIZE_HI: rd_val = fw_rd_ok ? 32'(exch_size_hi_q) : 32'h0000_0000;
         OFS_STATUS: begin
            rd_val[ST_MODE_LSB +: 3] = mode;
            rd_val[ST_MEM_FAULT] = mem_fault_q;
            rd_val[ST_SFR_DENY] = sfr_deny_q;
            rd_val[ST_SEG_LSB +: SEG_IDX_W] = exec_seg_q;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_pend_q) begin
         hrdata_q <= rd_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // segment table and pointer, writable in system mode only

   logic seg_wr;
   assign seg_wr = wr_pend_q && seg_cfg_ok; // [RULE19]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < SEG_COUNT; i++) begin
            seg_first_q[i] <= RST_ADDR;
            seg_last_q[i] <= RST_ADDR;
            seg_reloc_q[i] <= RST_ADDR;
            seg_rights_q[i] <= RST_RIGHTS; // [RULE4] [RULE5]
         end
      end else if (seg_wr) begin
         case (bus_addr_q) // [RULE2] [RULE3]
            OFS_SEG_FIRST: seg_first_q[seg_sel_q] <= hwdata[ADDR_W-1:0];
            OFS_SEG_LAST: seg_last_q[seg_sel_q] <= hwdata[ADDR_W-1:0];
            OFS_SEG_RELOC: seg_reloc_q[seg_sel_q] <= hwdata[ADDR_W-1:0];
            OFS_SEG_RIGHTS: seg_rights_q[seg_sel_q] <= hwdata[RIGHTS_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seg_sel_q <= '0;
         table_ptr_q <= RST_ADDR;
      end else if (seg_wr) begin
         if (bus_addr_q == OFS_SEG_SEL) begin
            seg_sel_q <= hwdata[SEG_IDX_W-1:0];
         end
         if (bus_addr_q == OFS_TABLE_PTR) begin
            table_ptr_q <= hwdata[ADDR_W-1:0]; // [RULE15]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // firewall registers

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fw_ctrl_lo_q <= RST_BYTE;
         fw_ctrl_hi_q <= RST_BYTE;
         exch_base_lo_q <= RST_BYTE;
         exch_base_hi_q <= RST_BYTE;
         exch_size_lo_q <= RST_BYTE;
         exch_size_hi_q <= RST_BYTE;
      end else if (wr_pend_q && fw_wr_ok) begin
         case (bus_addr_q) // [RULE14]
            OFS_FW_CTRL_LO: fw_ctrl_lo_q <= hwdata[7:0];
            OFS_FW_CTRL_HI: fw_ctrl_hi_q <= hwdata[7:0];
            OFS_EXCH_BASE_LO: exch_base_lo_q <= hwdata[7:0];
            OFS_EXCH_BASE_HI: exch_base_hi_q <= hwdata[7:0];
            OFS_EXCH_SIZE_LO: exch_size_lo_q <= hwdata[7:0];
            OFS_EXCH_SIZE_HI: exch_size_hi_q <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign hrdata = hrdata_q;
   assign mem_valid = mem_valid_q;
   assign mem_kind = mem_kind_q;
   assign mem_paddr = mem_paddr_q;
   assign mem_wdata = mem_wdata_q;
   assign mem_fault = mem_fault_q;
   assign sfr_ack = sfr_ack_q;
   assign sfr_wr = sfr_wr_q;
   assign sfr_wr_data = sfr_wr_data_q;
   assign sfr_rdata = sfr_rdata_q;
   assign sfr_deny = sfr_deny_q;

endmodule
